// ### design/bsl_defines.vh
// constants for the boot strap latch: register map, field positions, pull defaults
// assumes inclusion by every design file of the block; definitions only
`ifndef BSL_DEFINES_VH
`define BSL_DEFINES_VH

// register byte addresses
`define BSL_ADDR_CAPTURE 12'h000
`define BSL_ADDR_OVERRIDE 12'h004
`define BSL_ADDR_EFFECTIVE 12'h008
`define BSL_ADDR_STATUS 12'h00C
`define BSL_ADDR_W 12

// capture register field positions
`define BSL_BIT_LDO 0
`define BSL_BIT_BOOT 1
`define BSL_BIT_DLQ 2
`define BSL_BIT_LOG 3
`define BSL_BIT_EDGE 4
`define BSL_NSTRAP 5

// override register field positions
`define BSL_OVR_LDO_EN 0
`define BSL_OVR_LDO_VAL 1
`define BSL_OVR_SDIO_EN 2
`define BSL_OVR_SAMPLE_VAL 3
`define BSL_OVR_OUT_VAL 4
`define BSL_OVR_W 5

// status register field positions
`define BSL_ST_LATCHED 0
`define BSL_ST_DOWNLOAD 1

// pull defaults during reset, one bit per strap in capture order; then capture and override register reset values
`define BSL_PULL_UP_MASK 5'h1A
`define BSL_CAPTURE_RST 5'h00
`define BSL_OVR_RST 5'h00

`define BSL_ZERO32 32'h0000_0000

`endif

// ### design/bsl_pin_sync.v
// three-stage synchroniser for asynchronous pin levels
// assumes one clock; a change counts once stages two and three agree
`timescale 1ns/1ps
`include "bsl_defines.vh"

module bsl_pin_sync #(
  parameter W = 5
) (
  // clock and reset
  input wire ref_clk,
  input wire sys_rst,
  input wire [W-1:0] rst_val,
  // pins in, filtered level out
  input wire [W-1:0] pin_in,
  output reg [W-1:0] level_ff
);

  reg [W-1:0] s1_ff;
  reg [W-1:0] s2_ff;
  reg [W-1:0] s3_ff;

  always @(posedge ref_clk) begin
    s1_ff <= pin_in;
    s2_ff <= s1_ff;
    s3_ff <= s2_ff;
  end

  // per bit: follow only when the two later stages agree
  integer i;
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      level_ff <= rst_val;
    end else begin
      for (i = 0; i < W; i = i + 1) begin
        if (s2_ff[i] == s3_ff[i]) begin
          level_ff[i] <= s3_ff[i];
        end
      end
    end
  end

endmodule

// ### design/bsl_apb_slave.v
// apb register slave for the strap latch: capture, override, effective, status
// assumes apb master in the ref_clk domain; zero wait states
`timescale 1ns/1ps
`include "bsl_defines.vh"

module bsl_apb_slave (
  // clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  // block state
  input wire [`BSL_NSTRAP-1:0] capture,
  input wire [`BSL_NSTRAP-1:0] effective,
  input wire [1:0] status,
  output reg [`BSL_OVR_W-1:0] override_ff
);

  wire [`BSL_ADDR_W-1:0] addr = paddr[`BSL_ADDR_W-1:0];
  wire hit_hi = (paddr[31:`BSL_ADDR_W] == 20'h0_0000);
  wire access = psel & penable;

  function mapped;
    input [`BSL_ADDR_W-1:0] a;
    begin
      mapped = (a == `BSL_ADDR_CAPTURE) || (a == `BSL_ADDR_OVERRIDE) ||
               (a == `BSL_ADDR_EFFECTIVE) || (a == `BSL_ADDR_STATUS);
    end
  endfunction

  // zero wait states: error only on unmapped addresses
  assign pready = 1'b1;
  assign pslverr = access & ~(hit_hi & mapped(addr));

  // override is the only writable register; byte lane 0 carries it
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      override_ff <= `BSL_OVR_RST;
    end else if (access && pwrite && hit_hi && (addr == `BSL_ADDR_OVERRIDE) && pstrb[0]) begin
      override_ff <= pwdata[`BSL_OVR_W-1:0];
    end
  end

  always @* begin
    prdata = `BSL_ZERO32;
    if (hit_hi) begin
      case (addr)
        `BSL_ADDR_CAPTURE: prdata = {27'h000_0000, capture};
        `BSL_ADDR_OVERRIDE: prdata = {27'h000_0000, override_ff};
        `BSL_ADDR_EFFECTIVE: prdata = {27'h000_0000, effective};
        `BSL_ADDR_STATUS: prdata = {30'h0000_0000, status};
        default: prdata = `BSL_ZERO32;
      endcase
    end
  end

endmodule

// ### design/bsl_strap_latch.v
// boot strap latch top: samples five strap pins at reset release, holds them,
// decodes boot, supply, log and sdio settings, exposes everything over apb
// assumes strap pins asynchronous to ref_clk; one reset sys_rst covering
// power-on, rtc watchdog and brownout; pad pulls applied by the pad ring
`timescale 1ns/1ps
`include "bsl_defines.vh"

// Overview of operation
// - on reset release latch each of five strap pins as zero or one
// - latched bits stay fixed until the next sys_rst, later pin changes ignored
// - all five latched bits readable in the capture register
// - weak pulls enabled on every strap pin while reset is active
// - after release the pins return to normal functions
// - ldo strap 0 selects 3.3 V flash supply, 1 selects 1.8 V
// - boot strap 1 boots flash; both straps 0 enter download boot
// - log strap 1 prints boot log on tx pin, 0 keeps it silent
// - log strap picks sdio sampling edge, edge strap picks output edge
// - firmware may override supply voltage and sdio edges via register bits
module bsl_strap_latch (
  // clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // strap pins
  input wire strap_ldo_select_pin,
  input wire strap_boot_select_pin,
  input wire strap_download_qual_pin,
  input wire strap_log_timing_pin,
  input wire strap_sdio_edge_pin,
  // pad control
  output reg strap_pull_en_ff,
  output reg [`BSL_NSTRAP-1:0] strap_pull_up_ff,
  output reg strap_mode_ff,
  // decoded configuration
  output reg flash_supply_1v8_ff,
  output reg boot_from_flash_ff,
  output reg boot_download_ff,
  output reg boot_log_en_ff,
  output reg boot_log_tx_pin_mute_ff,
  output reg sdio_sample_rising_ff,
  output reg sdio_output_rising_ff,
  output reg strap_latched_ff,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire pready,
  output wire pslverr,
  output wire [31:0] prdata
);

  localparam ST_RESET = 2'b00;
  localparam ST_ARMED = 2'b01;
  localparam ST_HELD = 2'b10;

  wire [`BSL_NSTRAP-1:0] pins_raw;
  wire [`BSL_NSTRAP-1:0] pins_sync;
  wire [`BSL_OVR_W-1:0] override;
  reg [`BSL_NSTRAP-1:0] capture_ff;
  reg [`BSL_NSTRAP-1:0] nxt_capture;
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [`BSL_NSTRAP-1:0] effective;

  // fixed order in the capture word
  assign pins_raw[`BSL_BIT_LDO] = strap_ldo_select_pin;
  assign pins_raw[`BSL_BIT_BOOT] = strap_boot_select_pin;
  assign pins_raw[`BSL_BIT_DLQ] = strap_download_qual_pin;
  assign pins_raw[`BSL_BIT_LOG] = strap_log_timing_pin;
  assign pins_raw[`BSL_BIT_EDGE] = strap_sdio_edge_pin;

  // sync resets to the pull defaults so a floating pin reads its default
  bsl_pin_sync #(
    .W(`BSL_NSTRAP)
  ) u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .rst_val(`BSL_PULL_UP_MASK),
    .pin_in(pins_raw),
    .level_ff(pins_sync)
  );

  // sequence: reset -> armed (first cycle after release) -> held until the next sys_rst
  always @* begin
    nxt_state = state_ff;
    nxt_capture = capture_ff;
    case (state_ff)
      ST_RESET: nxt_state = ST_ARMED;
      ST_ARMED: begin
        nxt_capture = pins_sync;
        nxt_state = ST_HELD;
      end
      ST_HELD: nxt_state = ST_HELD;
      default: nxt_state = ST_RESET;
    endcase
  end

  // capture has no reset value dependency on pins; reset clears it to BSL_CAPTURE_RST and re-arms it
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      state_ff <= ST_RESET;
      capture_ff <= `BSL_CAPTURE_RST;
      strap_pull_en_ff <= 1'b1;
      strap_pull_up_ff <= `BSL_PULL_UP_MASK;
      strap_mode_ff <= 1'b1;
      strap_latched_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      capture_ff <= nxt_capture;
      // pulls and strap mode end with the release; pins go back to normal use
      strap_pull_en_ff <= 1'b0;
      strap_pull_up_ff <= strap_pull_up_ff;
      strap_mode_ff <= 1'b0;
      strap_latched_ff <= (state_ff == ST_ARMED) | strap_latched_ff;
    end
  end

  // firmware override wins over the strap for supply and sdio edges
  always @* begin
    effective = capture_ff;
    if (override[`BSL_OVR_LDO_EN]) begin
      effective[`BSL_BIT_LDO] = override[`BSL_OVR_LDO_VAL];
    end
    if (override[`BSL_OVR_SDIO_EN]) begin
      effective[`BSL_BIT_LOG] = override[`BSL_OVR_SAMPLE_VAL];
      effective[`BSL_BIT_EDGE] = override[`BSL_OVR_OUT_VAL];
    end
  end

  // decoded outputs are registered; boot log uses the raw strap, not the override
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      flash_supply_1v8_ff <= 1'b0;
      boot_from_flash_ff <= 1'b0;
      boot_download_ff <= 1'b0;
      boot_log_en_ff <= 1'b0;
      boot_log_tx_pin_mute_ff <= 1'b1;
      sdio_sample_rising_ff <= 1'b0;
      sdio_output_rising_ff <= 1'b0;
    end else if (strap_latched_ff) begin
      flash_supply_1v8_ff <= effective[`BSL_BIT_LDO];
      boot_from_flash_ff <= capture_ff[`BSL_BIT_BOOT];
      // boot=0 with qualifier=1 is undefined; neither mode is flagged
      boot_download_ff <= ~capture_ff[`BSL_BIT_BOOT] & ~capture_ff[`BSL_BIT_DLQ];
      boot_log_en_ff <= capture_ff[`BSL_BIT_LOG];
      boot_log_tx_pin_mute_ff <= ~capture_ff[`BSL_BIT_LOG];
      sdio_sample_rising_ff <= effective[`BSL_BIT_LOG];
      sdio_output_rising_ff <= effective[`BSL_BIT_EDGE];
    end
  end

  bsl_apb_slave u_apb (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .pready(pready),
    .pslverr(pslverr),
    .prdata(prdata),
    .capture(capture_ff),
    .effective(effective),
    .status({boot_download_ff, strap_latched_ff}),
    .override_ff(override)
  );

endmodule

// ### dv/bsl_strap_latch_chk.sv
// port assertions for the strap latch top
// assumes binding onto bsl_strap_latch, one clock domain
`timescale 1ns/1ps
module bsl_strap_latch_chk (
  // clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // pad control
  input wire strap_pull_en_ff,
  input wire [4:0] strap_pull_up_ff,
  input wire strap_mode_ff,
  // decoded configuration
  input wire boot_from_flash_ff,
  input wire boot_download_ff,
  input wire boot_log_en_ff,
  input wire boot_log_tx_pin_mute_ff,
  input wire strap_latched_ff,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire [31:0] prdata
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_pull_in_reset: assert property (disable iff (1'b0) sys_rst |=> strap_pull_en_ff && strap_mode_ff
    && strap_pull_up_ff == 5'h1A) else $error("pads not in strap mode during reset");
  a_pins_released: assert property (!sys_rst |=> !strap_pull_en_ff && !strap_mode_ff)
    else $error("strap mode kept after release");
  a_latch_timing: assert property ($fell(sys_rst) |-> !strap_latched_ff ##1 !strap_latched_ff
    ##1 strap_latched_ff) else $error("capture not two edges after release");
  a_latch_kept: assert property (strap_latched_ff |=> strap_latched_ff)
    else $error("latched flag dropped");
  a_boot_frozen: assert property (strap_latched_ff && $past(strap_latched_ff, 2) |->
    $stable(boot_from_flash_ff) && $stable(boot_download_ff) && $stable(boot_log_en_ff))
    else $error("boot settings moved after capture");
  a_mode_exclusive: assert property (boot_from_flash_ff |-> !boot_download_ff)
    else $error("flash and download boot both set");
  a_log_mute: assert property (strap_latched_ff && $past(strap_latched_ff) |->
    boot_log_tx_pin_mute_ff != boot_log_en_ff) else $error("log enable and mute agree");
  a_ready_access: assert property (psel && penable |-> pready)
    else $error("no ready in access phase");
  a_unmapped_err: assert property (psel && penable && !pwrite && paddr[31:12] != 0 |->
    pslverr && prdata == 32'h0000_0000) else $error("unmapped read not refused");
endmodule
bind bsl_strap_latch bsl_strap_latch_chk u_chk (.ref_clk, .sys_rst, .strap_pull_en_ff, .strap_pull_up_ff,
  .strap_mode_ff, .boot_from_flash_ff, .boot_download_ff, .boot_log_en_ff, .boot_log_tx_pin_mute_ff,
  .strap_latched_ff, .psel, .penable, .pwrite, .paddr, .pready, .pslverr, .prdata);

// ### dv/bsl_board_model.sv
// board side of the strap pins: host drive, pad pulls, else a moving level
// assumes pull controls come from the latch top
`timescale 1ns/1ps
module bsl_board_model (
  // clock
  input wire ref_clk,
  // host control
  input wire drive_en,
  input wire [4:0] drive_val,
  // pad pulls
  input wire pull_en,
  input wire [4:0] pull_up,
  // pins
  output reg [4:0] pins
);
  initial pins = 5'h00;
  always @(posedge ref_clk) begin
    if (drive_en)
      pins <= drive_val;
    else if (pull_en)
      pins <= pull_up;
    else
      pins <= ~pins; // released pins keep moving so a stale level cannot pass
  end
endmodule

// ### dv/bsl_strap_latch_tb.sv
// self-checking bench for the strap latch: boot patterns, overrides, apb refusals
// assumes bsl_board_model on the pins and the checker bound to the top
`timescale 1ns/1ps
`include "bsl_defines.vh"
module bsl_strap_latch_tb;
  localparam [24:0] pats = {5'h15, 5'h0A, 5'h04, 5'h1F, 5'h00};
  reg ref_clk, sys_rst, psel, penable, pwrite, drv_en, err;
  reg [31:0] paddr, pwdata, rd;
  reg [3:0] pstrb;
  reg [4:0] drv_val;
  wire [4:0] pins, pull_up;
  wire pull_en, pready, pslverr, f18, bff, bdl, blog, bmute, srise, orise;
  wire [31:0] prdata;
  integer n_errors, samples_checked, k;
  bsl_board_model board (.ref_clk(ref_clk), .drive_en(drv_en), .drive_val(drv_val), .pull_en(pull_en),
    .pull_up(pull_up), .pins(pins));
  bsl_strap_latch uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .strap_ldo_select_pin(pins[0]),
    .strap_boot_select_pin(pins[1]), .strap_download_qual_pin(pins[2]), .strap_log_timing_pin(pins[3]),
    .strap_sdio_edge_pin(pins[4]), .strap_pull_en_ff(pull_en), .strap_pull_up_ff(pull_up), .strap_mode_ff(),
    .flash_supply_1v8_ff(f18), .boot_from_flash_ff(bff), .boot_download_ff(bdl), .boot_log_en_ff(blog),
    .boot_log_tx_pin_mute_ff(bmute), .sdio_sample_rising_ff(srise), .sdio_output_rising_ff(orise),
    .strap_latched_ff(), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .prdata(prdata));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // one bit wider than a data word so an error flag can ride along with read data
  task cmp(input [32:0] got, input [32:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task conclude;
    begin
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task apb(input w, input [31:0] a, input [31:0] d);
    integer i;
    begin
      i = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1 && i < 16) begin
        @(posedge ref_clk);
        i = i + 1;
      end
      if (i == 16) begin
        n_errors = n_errors + 1;
        conclude;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  // d low leaves the pins to the pad pulls
  task boot(input [4:0] v, input d);
    reg [4:0] e;
    begin
      e = d ? v : `BSL_PULL_UP_MASK;
      drv_en <= d;
      drv_val <= v;
      sys_rst <= 1'b1;
      repeat (5) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      drv_en <= 1'b0;
      apb(1'b0, `BSL_ADDR_CAPTURE, 32'h0000_0000);
      cmp(rd, {27'h0, e});
      cmp(pull_en, 1'b0);
      cmp({f18, bff, bdl, blog, bmute, srise, orise}, {e[0], e[1], !e[1] && !e[2], e[3], !e[3], e[3], e[4]});
      apb(1'b0, `BSL_ADDR_STATUS, 32'h0000_0000);
      cmp(rd, {30'h0, !e[1] && !e[2], 1'b1});
    end
  endtask
  task override_and_refuse;
    begin
      apb(1'b1, `BSL_ADDR_OVERRIDE, 32'h0000_001F);
      // decoded outputs follow the override one edge after the write; wait until they are settled
      @(posedge ref_clk);
      cmp({f18, blog, srise, orise}, 4'b1011);
      apb(1'b0, `BSL_ADDR_EFFECTIVE, 32'h0000_0000);
      cmp(rd, 32'h0000_0019);
      pstrb <= 4'h0;
      apb(1'b1, `BSL_ADDR_OVERRIDE, 32'h0000_0000);
      pstrb <= 4'hF;
      apb(1'b0, `BSL_ADDR_OVERRIDE, 32'h0000_0000);
      cmp(rd, 32'h0000_001F);
      apb(1'b1, `BSL_ADDR_CAPTURE, 32'hFFFF_FFFF);
      apb(1'b0, `BSL_ADDR_CAPTURE, 32'h0000_0000);
      cmp({err, rd}, 33'h0);
      apb(1'b0, 32'h0000_1000, 32'h0000_0000);
      cmp({err, rd}, 33'h1_0000_0000);
    end
  endtask
  initial begin
    n_errors = 0;
    samples_checked = 0;
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    drv_en = 1'b0;
    drv_val = 5'h00;
    @(posedge ref_clk);
    boot(5'h00, 1'b0);
    for (k = 0; k < 5; k = k + 1)
      boot(pats[k*5 +: 5], 1'b1);
    boot(5'h00, 1'b1);
    override_and_refuse;
    conclude;
  end
endmodule
